// ==== logic/pll_params.svh ====
// constants for the clock synthesiser control block
`ifndef PLL_PARAMS_SVH
`define PLL_PARAMS_SVH
// register byte offsets
`define OFF_CTRL      8'h00
`define OFF_DIVIDERS  8'h04
`define OFF_AUX       8'h08
`define OFF_STATUS    8'h0c
`define OFF_DELAY     8'h10
`define OFF_FREQ      8'h14
// reset values
`define CTRL_RST      32'h0000_0001
`define DIV_RST       32'h0000_0100
`define AUX_RST       32'h0000_0040
`define DELAY_RST     32'h0000_0000
`define FREQ_RST      32'h0032_6464
// lock acquisition, in reference cycles
`define LOCK_REF_CYCLES 3
`define STEP_PS         250
`define AHB_OKAY        1'b0
`define HTRANS_NONSEQ   2'b10
`endif

// ==== logic/pll_pkg.sv ====
// shared types of the clock synthesiser control block
package pll_pkg;
    typedef enum logic [2:0] {
        FB_INTERNAL  = 3'b001,
        FB_CLOCKTREE = 3'b010,
        FB_EXTERNAL  = 3'b100
    } fb_src_t;
    typedef enum logic [2:0] {
        ST_RESET   = 3'b001,
        ST_ACQUIRE = 3'b010,
        ST_LOCKED  = 3'b100
    } lock_state_t;
    typedef struct packed {
        logic       zero;
        logic       lead;
        logic [2:0] steps;
    } delay_word_t;
endpackage

// ==== logic/pll_divider.sv ====
// programmable clock divider producing one-cycle ticks and a square level
`timescale 1ns/1ps
`default_nettype none
module pll_divider #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_reset_n,
    // control
    input  wire logic         i_enable,
    input  wire logic [W-1:0] i_divisor,
    input  wire logic         i_tick,
    // result
    output logic              o_tick,
    output logic              o_level
);
    logic [W-1:0] count_reg;   // ticks seen this period
    logic [W-1:0] half;        // point of level fall

    assign half = i_divisor >> 1;

    // counts input ticks, wraps at divisor
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || !i_enable) begin
            count_reg <= '0;
            o_tick    <= 1'b0;
            o_level   <= 1'b0;
        end else if (i_tick) begin
            if (count_reg + W'(1) >= i_divisor) begin
                count_reg <= '0;
                o_tick    <= 1'b1;
                // divisor one toggles, else level would stick high
                o_level   <= (i_divisor <= W'(1)) ? !o_level : 1'b1;
            end else begin
                count_reg <= count_reg + W'(1);
                o_tick    <= 1'b0;
                o_level   <= count_reg + W'(1) < half;
            end
        end else begin
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== logic/pll_clock_synth_ctrl.sv ====
// behavioural clock synthesiser with lock, delay adjust and register port
// What this block does
// R01: aux clock phase in 45 degree steps; here in reference periods, 45 degrees when ref/feedback is eight
// R02: aux duty cycle in eighths of period; here in reference periods, eighths when ref/feedback is eight
// R03: lock rises after valid reference and lock time
// R04: lost reference or feedback drops lock
// R05: fabric must reset after lock loss
// R06: fabric may build reset from lock
// R07: static fine delay signed -8 to +8; here the 5-bit field takes -16 to +15 unclamped
// R08: feedback source internal, clocktree or external
// R09: internal feedback taps main divider output
// R10: static policy ignores dynamic delay inputs
// R11: select high uses pins, low static
// R12: delay zero input forces zero delay
// R13: direction one leads, zero lags
// R14: delay setting visible on readback outputs
// R15: frequency settings choose dividers, defaults given; here freq_reg is only stored and read back, dividers come from dividers_reg
// R16: aux clock never used as feedback
// R17: lock two to four reference cycles after reset
// R18: reset clears counters then acquisition restarts
// R19: reference and feedback dividers span 1 to 16
// R20: slow clock is main over even 2..128
// R21: fabric resets after dynamic delay change
// R22: lock held low during reset
// R23: lead or lag shifts all outputs equally; here the delay only drives the readback outputs, no clock is shifted
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pll_params.svh"
module pll_clock_synth_ctrl
    import pll_pkg::*;
#(
    parameter int DIV_W       = 8,
    parameter int LOCK_CYCLES = `LOCK_REF_CYCLES
) (
    // system clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // clock pins, sampled
    input  wire logic        i_ref_clk_in,
    input  wire logic        i_feedback_clk_in,
    input  wire logic        i_loop_reset,
    // dynamic delay pins
    input  wire logic        i_delay_ctrl_select,
    input  wire logic        i_delay_zero_in,
    input  wire logic        i_delay_direction_in,
    input  wire logic [2:0]  i_delay_steps_in,
    // clock outputs and status
    output logic             o_main_clk_out,
    output logic             o_aux_phase_clk_out,
    output logic             o_slow_clk_out,
    output logic             o_lock,
    output logic             o_delay_zero_out,
    output logic             o_delay_direction_out,
    output logic [2:0]       o_delay_steps_out
);
    // registers seen by software
    logic [31:0] ctrl_reg;      // [0] clocktree,[1] internal,[2] external,[4] dynamic policy
    logic [31:0] dividers_reg;  // [7:0] ref,[15:8] feedback,[23:16] main,[31:24] slow
    logic [31:0] aux_reg;       // [2:0] coarse_phase_sel,[6:4] duty eighths
    logic [31:0] delay_reg;     // [4:0] fine_delay_steps, signed
    logic [31:0] freq_reg;      // [7:0] ref,[15:8] main,[23:16] slow, in MHz

    // bus address phase capture
    logic        wr_pend_reg;
    logic [7:0]  addr_reg;

    // pin synchronisers, two stages each
    logic [4:0]  sync1_reg;
    logic [4:0]  sync2_reg;
    logic [4:0]  dly_pins1_reg;
    logic [4:0]  dly_pins2_reg;
    logic        ref_prev_reg;
    logic        fb_prev_reg;
    logic        ref_rise;
    logic        fb_rise;

    lock_state_t state_reg;
    logic [3:0]  acq_count_reg;   // reference edges since acquisition began
    logic [7:0]  ref_gap_reg;     // cycles since last reference edge
    logic [7:0]  fb_gap_reg;      // cycles since last feedback edge
    fb_src_t     fb_src;
    logic        run;
    logic        main_tick;
    logic        main_level;
    logic        slow_level;
    logic [2:0]  aux_count_reg;   // reference edges since last main tick
    logic [4:0]  eff_delay;       // signed applied steps
    delay_word_t dyn_word;

    // clamps divider fields into legal span
    function automatic logic [DIV_W-1:0] clamp16(input logic [7:0] v);
        clamp16 = (v == 8'h00) ? DIV_W'(1) : (v > 8'h10) ? DIV_W'(16) : DIV_W'(v);
    endfunction

    // decodes the feedback one-hot choice, clocktree when none set
    function automatic fb_src_t fb_decode(input logic [2:0] b);
        if (b[1])
            fb_decode = FB_INTERNAL;
        else if (b[2])
            fb_decode = FB_EXTERNAL;
        else
            fb_decode = FB_CLOCKTREE; // R08
    endfunction

    assign fb_src = fb_decode(ctrl_reg[2:0]);
    assign run    = (state_reg != ST_RESET);

    // ahb address phase: latch writes for the data phase
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else if (i_hready) begin
            wr_pend_reg <= i_hsel && (i_htrans == `HTRANS_NONSEQ) && i_hwrite;
            addr_reg    <= i_haddr[7:0];
        end
    end

    // zero-wait slave, always okay
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_hreadyout <= 1'b1;
            o_hresp     <= `AHB_OKAY;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp     <= `AHB_OKAY;
        end
    end

    // read data registered during address phase; unmapped reads zero
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (i_hready && i_hsel && !i_hwrite) begin
            case (i_haddr[7:0])
                `OFF_CTRL:     o_hrdata <= ctrl_reg;
                `OFF_DIVIDERS: o_hrdata <= dividers_reg;
                `OFF_AUX:      o_hrdata <= aux_reg;
                `OFF_STATUS:   o_hrdata <= {24'h000000, o_delay_zero_out,
                                            o_delay_direction_out, o_delay_steps_out,
                                            state_reg == ST_LOCKED, fb_src == FB_INTERNAL,
                                            o_lock};
                `OFF_DELAY:    o_hrdata <= delay_reg;
                `OFF_FREQ:     o_hrdata <= freq_reg;
                default:       o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // register writes in the data phase
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            ctrl_reg     <= `CTRL_RST;
            dividers_reg <= `DIV_RST | 32'h0804_0101;
            aux_reg      <= `AUX_RST;
            delay_reg    <= `DELAY_RST;
            freq_reg     <= `FREQ_RST;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                `OFF_CTRL:     ctrl_reg     <= {27'h0, i_hwdata[4], 1'b0, i_hwdata[2:0]};
                `OFF_DIVIDERS: dividers_reg <= i_hwdata;
                `OFF_AUX:      aux_reg      <= {25'h0, i_hwdata[6:4], 1'b0, i_hwdata[2:0]};
                `OFF_DELAY:    delay_reg    <= {27'h0, i_hwdata[4:0]};
                `OFF_FREQ:     freq_reg     <= {8'h00, i_hwdata[23:0]};
                default:       ;
            endcase
        end
    end

    // two-flop synchronisers on every pin
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            sync1_reg     <= 5'h00;
            sync2_reg     <= 5'h00;
            dly_pins1_reg <= 5'h00;
            dly_pins2_reg <= 5'h00;
        end else begin
            sync1_reg     <= {i_delay_ctrl_select, i_loop_reset, i_feedback_clk_in,
                              i_ref_clk_in, 1'b0};
            sync2_reg     <= sync1_reg;
            dly_pins1_reg <= {i_delay_zero_in, i_delay_direction_in, i_delay_steps_in};
            dly_pins2_reg <= dly_pins1_reg;
        end
    end

    // edge detection on synchronised clocks
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            ref_prev_reg <= 1'b0;
            fb_prev_reg  <= 1'b0;
        end else begin
            ref_prev_reg <= sync2_reg[1];
            fb_prev_reg  <= sync2_reg[2];
        end
    end
    assign ref_rise = sync2_reg[1] && !ref_prev_reg;
    // feedback: external pin, else internal tap of our own main clock
    assign fb_rise  = (fb_src == FB_EXTERNAL) ? (sync2_reg[2] && !fb_prev_reg) : main_tick; // R09 R16

    // edge watchdogs; a silent input counts as invalid
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || !run) begin
            ref_gap_reg <= 8'h00;
            fb_gap_reg  <= 8'h00;
        end else begin
            ref_gap_reg <= ref_rise ? 8'h00 : (ref_gap_reg == 8'hff ? 8'hff : ref_gap_reg + 8'h01);
            fb_gap_reg  <= (fb_rise || state_reg != ST_LOCKED) ? 8'h00 :
                           (fb_gap_reg == 8'hff ? 8'hff : fb_gap_reg + 8'h01);
        end
    end

    // lock state machine; relocks by itself once reference edges return after a loss
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || sync2_reg[3]) begin
            state_reg     <= ST_RESET;     // R18 R22
            acq_count_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_RESET: begin
                    state_reg     <= ST_ACQUIRE;
                    acq_count_reg <= 4'h0;
                end
                ST_ACQUIRE: begin
                    if (ref_gap_reg == 8'hff) begin
                        acq_count_reg <= 4'h0;
                    end else if (ref_rise) begin
                        if (acq_count_reg + 4'h1 >= 4'(LOCK_CYCLES))
                            state_reg <= ST_LOCKED; // R03 R17
                        acq_count_reg <= acq_count_reg + 4'h1;
                    end
                end
                ST_LOCKED: begin
                    if (ref_gap_reg == 8'hff || fb_gap_reg == 8'hff)
                        state_reg <= ST_ACQUIRE;   // R04 R05
                    acq_count_reg <= 4'hf;
                end
                default: state_reg <= ST_RESET;
            endcase
        end
    end

    // lock output; after a loss it rises again when acquisition relocks, no fabric reset needed
    always_ff @(posedge i_clock) begin
        if (!i_reset_n)
            o_lock <= 1'b0;
        else
            o_lock <= (state_reg == ST_LOCKED) && !sync2_reg[3]; // R22 R06
    end

    // main divider ticks on reference edges, scaled by feedback over reference
    pll_divider #(.W(DIV_W)) u_main (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_enable  (run),
        .i_divisor (clamp16(dividers_reg[7:0]) / clamp16(dividers_reg[15:8]) == '0 ?
                    DIV_W'(1) : clamp16(dividers_reg[7:0]) / clamp16(dividers_reg[15:8])), // R19 R15
        .i_tick    (ref_rise),
        .o_tick    (main_tick),
        .o_level   (main_level)
    );

    // slow clock: main divided by even setting 2..128
    pll_divider #(.W(DIV_W)) u_slow (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_enable  (run),
        .i_divisor ({dividers_reg[31:25], 1'b0} < 8'h02 ? DIV_W'(2) :
                    {dividers_reg[31:25] > 7'h40 ? 7'h40 : dividers_reg[31:25], 1'b0}), // R20
        .i_tick    (main_tick),
        .o_tick    (),
        .o_level   (slow_level)
    );

    // phase counter for the aux output: reference edges since the last main tick, eighths only when ref over feedback is eight
    always_ff @(posedge i_clock) begin
        if (!i_reset_n || !run)
            aux_count_reg <= 3'h0;
        else if (main_tick || ref_rise)
            aux_count_reg <= main_tick ? 3'h0 : aux_count_reg + 3'h1;
    end

    // delay source: policy, select pin, zero, direction, steps
    assign dyn_word = delay_word_t'(dly_pins2_reg);
    always_comb begin
        if (ctrl_reg[4] && sync2_reg[4]) begin          // R10 R11
            if (dyn_word.zero)
                eff_delay = 5'h00;                      // R12
            else if (dyn_word.lead)
                eff_delay = -(5'(dyn_word.steps) + 5'h01); // R13
            else
                eff_delay = 5'(dyn_word.steps) + 5'h01;
        end else begin
            eff_delay = delay_reg[4:0];                 // R07
        end
    end

    // outputs; delay is not applied to the three clocks, only reported on the readback outputs
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_main_clk_out        <= 1'b0;
            o_aux_phase_clk_out   <= 1'b0;
            o_slow_clk_out        <= 1'b0;
            o_delay_zero_out      <= 1'b0;
            o_delay_direction_out <= 1'b0;
            o_delay_steps_out     <= 3'h0;
        end else begin
            o_main_clk_out      <= main_level;                       // R23
            // window starts at phase eighth, lasts duty eighths
            o_aux_phase_clk_out <= run && (3'(aux_count_reg - aux_reg[2:0]) <
                                   aux_reg[6:4]);                    // R01 R02
            o_slow_clk_out      <= slow_level;
            o_delay_zero_out      <= eff_delay == 5'h00;             // R14
            o_delay_direction_out <= eff_delay[4];
            o_delay_steps_out     <= eff_delay[4] ? 3'(-eff_delay - 5'h01) :
                                     3'(eff_delay - 5'h01);
        end
    end
endmodule
`default_nettype wire

// ==== tb/pll_clock_synth_ctrl_properties.sv ====
// port checker for the clock synthesiser
`timescale 1ns/1ps
`default_nettype none
module pll_ctrl_checker (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_reset_n,
    // bus side
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    // loop and delay pins
    input wire logic        i_ref_clk_in,
    input wire logic        i_loop_reset,
    input wire logic        i_delay_ctrl_select,
    input wire logic        i_delay_zero_in,
    input wire logic        i_delay_direction_in,
    input wire logic [2:0]  i_delay_steps_in,
    input wire logic        o_lock,
    input wire logic        o_delay_zero_out,
    input wire logic        o_delay_direction_out,
    input wire logic [2:0]  o_delay_steps_out
);
    logic       ap_wr;     // write data phase in progress
    logic [7:0] ap_addr;   // its byte offset
    logic       dyn_pol;   // delay policy as software last wrote it
    logic       ref_q;     // reference one cycle back
    logic [8:0] ref_idle;  // cycles reference stood still
    wire take = i_hsel && i_hready && i_htrans == 2'h2;
    // shadow of the policy bit, registers unseen here
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            ap_wr <= 1'h0;
            ap_addr <= 8'h00;
            dyn_pol <= 1'h0;
        end else begin
            ap_wr <= take && i_hwrite;
            ap_addr <= i_haddr[7:0];
            if (ap_wr && ap_addr == 8'h00) dyn_pol <= i_hwdata[4];
        end
    end
    // stops at 300, no wrap
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            ref_q <= 1'h0;
            ref_idle <= 9'h000;
        end else begin
            ref_q <= i_ref_clk_in;
            if (ref_q != i_ref_clk_in) ref_idle <= 9'h000;
            else if (ref_idle != 9'h12c) ref_idle <= ref_idle + 9'h001;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // pins steady in dynamic mode past the synchronisers
    sequence s_dyn_steady;
        (dyn_pol && i_delay_ctrl_select && !i_loop_reset
         && $stable({i_delay_zero_in, i_delay_direction_in, i_delay_steps_in}))[*5];
    endsequence
    // static policy, no writes
    sequence s_static_quiet;
        (!dyn_pol && !ap_wr && !i_loop_reset)[*6];
    endsequence
    a_lock_low_reset: assert property (i_loop_reset [*5] |-> !o_lock)
        else $error("lock high during loop reset");
    a_lock_not_early: assert property ($fell(i_loop_reset) |-> !o_lock [*5])
        else $error("lock rose too early");
    a_lock_drop_idle: assert property (ref_idle >= 9'h10e |-> !o_lock)
        else $error("lock kept without reference");
    a_dyn_zero: assert property (s_dyn_steady ##0 i_delay_zero_in |-> o_delay_zero_out)
        else $error("zero input not applied");
    a_dyn_follow: assert property (s_dyn_steady ##0 !i_delay_zero_in |->
        !o_delay_zero_out && o_delay_direction_out == i_delay_direction_in
        && o_delay_steps_out == i_delay_steps_in)
        else $error("dynamic delay not reflected");
    a_static_hold: assert property (s_static_quiet |->
        $stable({o_delay_zero_out, o_delay_direction_out, o_delay_steps_out}))
        else $error("static delay moved");
    a_status_read: assert property (take && !i_hwrite && i_haddr == 32'h0000_000c |=>
        o_hrdata[0] == $past(o_lock) && o_hrdata[7:3] ==
        $past({o_delay_zero_out, o_delay_direction_out, o_delay_steps_out}))
        else $error("status word wrong");
    a_unmapped_read: assert property (take && !i_hwrite && i_haddr == 32'h0000_0020 |=>
        o_hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus not ready or error");
endmodule
bind pll_clock_synth_ctrl pll_ctrl_checker chk (.*);
`default_nettype wire

// ==== tb/pll_fabric_model.sv ====
// fabric-side model: reference source, feedback echo and loop reset
`timescale 1ns/1ps
`default_nettype none
module pll_fabric_model (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset_n,
    // bench commands
    input  wire logic i_ref_run,
    input  wire logic i_kick,
    // from the synthesiser
    input  wire logic i_lock,
    input  wire logic i_main_clk,
    // to the synthesiser
    output logic      o_ref_clk,
    output logic      o_fb_clk,
    output logic      o_loop_reset
);
    logic       half;     // reference half period is two cycles
    logic [2:0] rst_cnt;  // cycles of loop reset still to drive
    logic       lock_q;   // lock, one cycle back
    // reference stands still while stopped
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            half <= 1'h0;
            o_ref_clk <= 1'h0;
        end else if (i_ref_run) begin
            half <= !half;
            if (half) o_ref_clk <= !o_ref_clk;
        end
    end
    // feedback echoes the main clock, never the shifted one
    assign o_fb_clk = i_main_clk;
    // reset pulse at power-up, on request, and whenever lock drops
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            rst_cnt <= 3'h6;
            lock_q <= 1'h0;
        end else begin
            lock_q <= i_lock;
            if (i_kick || (lock_q && !i_lock)) rst_cnt <= 3'h6;
            else if (rst_cnt != 3'h0) rst_cnt <= rst_cnt - 3'h1;
        end
    end
    assign o_loop_reset = rst_cnt != 3'h0;
endmodule
`default_nettype wire

// ==== tb/pll_clock_synth_ctrl_bench.sv ====
// bench for the clock synthesiser
`timescale 1ns/1ps
`default_nettype none
module pll_clock_synth_ctrl_bench;
    logic        i_clock, i_reset_n, hsel, hwrite, ref_run, kick;
    logic        sel, zr, dir;
    logic [2:0]  steps;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata;
    wire  [31:0] hrdata;
    wire  logic  hready, hresp, ref_clk, fb_clk, loop_reset, main, aux, slow, lock, zo, dro;
    wire  [2:0]  so;
    int          err_total = 0;
    int          checks = 0;
    pll_clock_synth_ctrl uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_ref_clk_in(ref_clk), .i_feedback_clk_in(fb_clk),
        .i_loop_reset(loop_reset), .i_delay_ctrl_select(sel), .i_delay_zero_in(zr),
        .i_delay_direction_in(dir), .i_delay_steps_in(steps), .o_main_clk_out(main),
        .o_aux_phase_clk_out(aux), .o_slow_clk_out(slow), .o_lock(lock),
        .o_delay_zero_out(zo), .o_delay_direction_out(dro), .o_delay_steps_out(so));
    pll_fabric_model fab (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_ref_run(ref_run),
        .i_kick(kick), .i_lock(lock), .i_main_clk(main), .o_ref_clk(ref_clk),
        .o_fb_clk(fb_clk), .o_loop_reset(loop_reset));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one single-word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge i_clock);
        hsel <= 1'h1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge i_clock); while (hready !== 1'h1);
        hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
        do @(posedge i_clock); while (hready !== 1'h1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a, exp, input string nm);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask
    // ask the fabric for a loop reset
    task automatic pulse_kick;
        @(posedge i_clock) kick <= 1'h1;
        @(posedge i_clock) kick <= 1'h0;
    endtask
    task automatic wait_lock(input logic exp, input int lim, input string nm);
        for (int n = 0; lock !== exp && n < lim; n++) @(negedge i_clock);
        chk(nm, {31'h0, lock}, {31'h0, exp});
    endtask
    task automatic t_regs;
        rd(32'h00, 32'h1, "ctrl reset");
        rd(32'h08, 32'h40, "aux reset");
        rd(32'h10, 32'h0, "delay reset");
        rd(32'h14, 32'h0032_6464, "freq reset");
        wr(32'h14, 32'h0019_6432);
        rd(32'h14, 32'h0019_6432, "freq store");
        wr(32'h20, 32'hffff_ffff);
        rd(32'h20, 32'h0, "unmapped");
        for (int p = 0; p < 8; p++) begin
            wr(32'h08, {25'h0, p[2:0] | 3'h1, 1'h0, p[2:0]});
            rd(32'h08, {25'h0, p[2:0] | 3'h1, 1'h0, p[2:0]}, "aux setting");
        end
        wr(32'h08, 32'h40);
        $display("t_regs done");
    endtask
    task automatic t_fb;
        logic [31:0] q, v;
        for (int i = 0; i < 3; i++) begin
            v = 32'h1 << i;
            wr(32'h00, v);
            rd(32'h00, v, "fb source");
            bus(1'h0, 32'h0c, 32'h0, q);
            chk("internal tap", {31'h0, q[1]}, {31'h0, v[1]});
        end
        wr(32'h00, 32'h1);
        $display("t_fb done");
    endtask
    task automatic t_lock;
        int n;
        pulse_kick;
        repeat (5) @(negedge i_clock);
        chk("lock in reset", {31'h0, lock}, 32'h0);
        while (loop_reset !== 1'h0) @(negedge i_clock);
        for (n = 0; lock !== 1'h1 && n < 80; n++) @(negedge i_clock);
        chk("lock time", {31'h0, n > 5 && n < 25}, 32'h1);
        $display("t_lock done");
    endtask
    task automatic t_dyn;
        logic [4:0] fine [2] = '{5'h1d, 5'h03};
        wr(32'h00, 32'h11);
        @(posedge i_clock) sel <= 1'h1;
        for (int i = 0; i < 16; i++) begin
            @(posedge i_clock) {dir, steps} <= i[3:0];
            repeat (6) @(negedge i_clock);
            chk("dyn readback", {27'h0, zo, dro, so}, {28'h0, i[3:0]});
        end
        @(posedge i_clock) zr <= 1'h1;
        repeat (6) @(negedge i_clock);
        chk("dyn zero", {31'h0, zo}, 32'h1);
        @(posedge i_clock) sel <= 1'h0;
        for (int i = 0; i < 2; i++) begin
            wr(32'h10, {27'h0, fine[i]});
            repeat (6) @(negedge i_clock);
            chk("static delay", {27'h0, zo, dro, so}, {28'h0, i[0] == 0, 3'h2});
        end
        wr(32'h10, 32'h0);
        wr(32'h00, 32'h01);
        @(posedge i_clock) {sel, zr, dir, steps} <= 6'h27;
        repeat (6) @(negedge i_clock);
        chk("static policy", {31'h0, zo}, 32'h1);
        pulse_kick;
        wait_lock(1'h1, 80, "relock");
        $display("t_dyn done");
    endtask
    task automatic t_loss;
        @(posedge i_clock) ref_run <= 1'h0;
        wait_lock(1'h0, 400, "lock loss");
        @(posedge i_clock) ref_run <= 1'h1;
        wait_lock(1'h1, 100, "reacquire");
        $display("t_loss done");
    endtask
    task automatic t_slow;
        int mr = 0, sr = 0, ar = 0;
        logic pm, ps, pa;
        // ref over feedback of eight gives the aux counter all eight phases
        wr(32'h04, 32'h0200_0108);
        rd(32'h04, 32'h0200_0108, "dividers");
        pm = main; ps = slow; pa = aux;
        repeat (1600) begin
            @(negedge i_clock);
            if (main && !pm) mr++;
            if (slow && !ps) sr++;
            if (aux && !pa) ar++;
            pm = main; ps = slow; pa = aux;
        end
        chk("main runs", {31'h0, mr > 20}, 32'h1);
        chk("slow ratio", {31'h0, mr >= 2 * sr - 2 && mr <= 2 * sr + 2}, 32'h1);
        chk("aux rate", {31'h0, ar >= mr - 2 && ar <= mr + 2}, 32'h1);
        $display("t_slow done");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // free-running system clock
    initial begin
        i_clock = 1'h0;
        forever #50 i_clock = ~i_clock;
    end
    // hang guard, tests take under 5000 cycles
    initial begin
        repeat (20000) @(posedge i_clock);
        err_total++;
        close_out;
    end
    // main sequence
    initial begin
        i_reset_n = 1'h0; hsel = 1'h0; hwrite = 1'h0; htrans = 2'h0;
        haddr = 32'h0; hwdata = 32'h0; ref_run = 1'h1; kick = 1'h0;
        sel = 1'h0; zr = 1'h0; dir = 1'h0; steps = 3'h0;
        repeat (20) @(posedge i_clock);
        i_reset_n <= 1'h1;
        t_regs;
        t_fb;
        t_lock;
        t_dyn;
        t_loss;
        t_slow;
        close_out;
    end
endmodule
`default_nettype wire
